// *** rtl/spm_params.svh ***
/*
  Constants for the supervisor and power mode controller.
  Assumes a 100 MHz device clock and inclusion by bare name.
*/
// How it works
// - Chip stays in reset from power-up until every supply reports good.
// - Any supply dropping forces reset until all good, then cold restart.
// - Watchdog is a 16-bit counter of 1 ms ticks, 1 ms to 65 s.
// - Watchdog counts on its own, sharing nothing with the real-time counter.
// - Watchdog expiry without refresh resets the whole chip.
// - Software can read whether the last reset came from the watchdog.
// - Watchdog runs and is clocked only in the running state.
// - Running, deep-sleep and intermediate transition states form the controller.
// - Sleep starts on a software control write or a USB standby request.
// - Wake acts only in deep sleep; early stimuli are held until then.
// - Wake on designated pin assert or deassert, edge chosen by software.
// - Wake when the 64-bit real-time counter reaches the compare value.
// - Wake on USB host wakeup when USB is enabled.
// - While running, real-time counter adds one per main oscillator tick.
// - In deep sleep the counter may switch to the 31,250 Hz clock.
// - On low-power clock the counter adds a programmable increment per tick.
// - Deep sleep powers down the digital node and most peripherals.
// - A 128-byte memory keeps its contents through deep sleep.
// - Supply loss during either transition sequence issues full system reset.
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

`define SPM_CLK_HZ          100000000
`define SPM_MS_PER_TICK     1
`define SPM_WDT_TICK_CYC    ((`SPM_CLK_HZ / 1000) * `SPM_MS_PER_TICK)
`define SPM_LP_HZ           31250
`define SPM_LP_TICK_CYC     (`SPM_CLK_HZ / `SPM_LP_HZ)
`define SPM_SEQ_STEP_CYC    4
`define SPM_MEM_BYTES       128
`define SPM_WDT_RESET       16'hffff
`define SPM_LP_INC_RESET    64'h0000_0000_0000_0c80

`endif

// *** rtl/spm_pkg.sv ***
/*
  Types for the supervisor and power mode controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spm_pkg;
  // Gray-coded along awake -> down1 -> down2 -> asleep -> up1 -> up2; up2 -> awake flips all three bits
  typedef enum logic [2:0] {
    SPM_AWAKE  = 3'b000,
    SPM_DOWN1  = 3'b001,
    SPM_DOWN2  = 3'b011,
    SPM_ASLEEP = 3'b010,
    SPM_UP1    = 3'b110,
    SPM_UP2    = 3'b111
  } spm_state_e;
endpackage

// *** rtl/spm_sleep_mem.sv ***
/*
  Retained byte memory kept through deep sleep.
  Assumes its supply stays on in sleep; it has no reset on purpose.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_sleep_mem #(
  parameter int DEPTH = 128
) (
  input  wire logic                     mclk_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] addr_in,
  input  wire logic [7:0]               wdata_in,
  output logic      [7:0]               rdata_out
);
  logic [7:0] mem_reg [DEPTH];

  // No reset: contents must survive sleep and chip resets alike
  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_reg[addr_in] <= wdata_in;
    end
    rdata_out <= mem_reg[addr_in];
  end
endmodule
`default_nettype wire

// *** rtl/spm_top.sv ***
/*
  Supervisor (power-on, brown-out, watchdog) and power mode controller
  with real-time counter and deep-sleep wake logic.
  Assumes synchronous inputs, one 100 MHz clock and a tick pulse from the
  low-power oscillator already brought into this clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spm_params.svh"
module spm_top #(
  parameter int WDT_W    = 16,
  parameter int RTC_W    = 64,
  parameter int MEM_DEPTH = `SPM_MEM_BYTES,
  parameter int TICK_CYC = `SPM_WDT_TICK_CYC,
  parameter int STEP_CYC = `SPM_SEQ_STEP_CYC
) (
  input  wire logic                         mclk_in,
  input  wire logic                         rst_in,
  input  wire logic [1:0]                   supply_good_in,
  input  wire logic                         wdt_enable_in,
  input  wire logic [WDT_W-1:0]             wdt_timeout_in,
  input  wire logic                         wdt_refresh_in,
  input  wire logic                         wdt_cause_clear_in,
  input  wire logic                         sw_sleep_req_in,
  input  wire logic                         usb_standby_req_in,
  input  wire logic                         usb_enable_in,
  input  wire logic                         usb_wake_in,
  input  wire logic                         wake_pin_in,
  input  wire logic                         wake_pin_en_in,
  input  wire logic                         wake_pin_rise_in,
  input  wire logic                         rtc_wake_en_in,
  input  wire logic [RTC_W-1:0]             rtc_compare_in,
  input  wire logic                         lp_clk_sel_in,
  input  wire logic [RTC_W-1:0]             lp_increment_in,
  input  wire logic                         lp_tick_in,
  input  wire logic                         mem_wr_in,
  input  wire logic [$clog2(MEM_DEPTH)-1:0] mem_addr_in,
  input  wire logic [7:0]                   mem_wdata_in,
  output logic      [7:0]                   mem_rdata_out,
  output logic                              chip_reset_out,
  output logic                              wdt_reset_cause_out,
  output logic      [WDT_W-1:0]             wdt_count_out,
  output logic      [RTC_W-1:0]             rtc_value_out,
  output logic                              digital_power_en_out,
  output logic                              awake_out,
  output logic                              asleep_out,
  output logic      [2:0]                   power_state_out
);
  // ----------------------------------------------------------------
  // Supervisor
  // ----------------------------------------------------------------
  logic                   all_good;
  logic                   wdt_expire;
  logic                   seq_fail;
  logic                   chip_rst;
  spm_pkg::spm_state_e    state_reg;
  spm_pkg::spm_state_e    state_next;

  assign all_good = &supply_good_in;
  assign seq_fail = !all_good && state_reg != spm_pkg::SPM_AWAKE
                    && state_reg != spm_pkg::SPM_ASLEEP;

  // Held while any supply is low, released only when all are good again
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      chip_reset_out <= 1'b1;
    end else begin
      chip_reset_out <= !all_good || wdt_expire || seq_fail;
    end
  end
  assign chip_rst = rst_in || chip_reset_out;

  // ----------------------------------------------------------------
  // Power mode controller
  // ----------------------------------------------------------------
  logic [$clog2(STEP_CYC+1)-1:0] step_reg;
  logic                          step_done;
  logic                          sleep_req;
  logic                          wake_req;

  assign step_done = step_reg == '0;
  // Requests outside awake are ignored; the far side should not issue them
  assign sleep_req = sw_sleep_req_in || usb_standby_req_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spm_pkg::SPM_AWAKE: begin
        if (sleep_req) begin
          state_next = spm_pkg::SPM_DOWN1;
        end
      end
      spm_pkg::SPM_DOWN1: begin
        if (step_done) begin
          state_next = spm_pkg::SPM_DOWN2;
        end
      end
      spm_pkg::SPM_DOWN2: begin
        if (step_done) begin
          state_next = spm_pkg::SPM_ASLEEP;
        end
      end
      spm_pkg::SPM_ASLEEP: begin
        if (wake_req) begin
          state_next = spm_pkg::SPM_UP1;
        end
      end
      spm_pkg::SPM_UP1: begin
        if (step_done) begin
          state_next = spm_pkg::SPM_UP2;
        end
      end
      spm_pkg::SPM_UP2: begin
        if (step_done) begin
          state_next = spm_pkg::SPM_AWAKE;
        end
      end
      default: state_next = spm_pkg::SPM_AWAKE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      state_reg <= spm_pkg::SPM_AWAKE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Each transitional state dwells a fixed number of cycles
  always_ff @(posedge mclk_in) begin
    if (chip_rst || state_next != state_reg) begin
      step_reg <= ($clog2(STEP_CYC+1))'(STEP_CYC - 1);
    end else if (!step_done) begin
      step_reg <= step_reg - 1'b1;
    end
  end

  assign awake_out       = state_reg == spm_pkg::SPM_AWAKE;
  assign asleep_out      = state_reg == spm_pkg::SPM_ASLEEP;
  assign power_state_out = state_reg;

  // Digital node loses power through down2, asleep and up1
  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      digital_power_en_out <= 1'b1;
    end else begin
      digital_power_en_out <= !(state_next == spm_pkg::SPM_DOWN2
                                || state_next == spm_pkg::SPM_ASLEEP
                                || state_next == spm_pkg::SPM_UP1);
    end
  end

  // ----------------------------------------------------------------
  // Wake stimuli
  // ----------------------------------------------------------------
  logic pin_prev_reg;
  logic pin_event;
  logic wake_pend_reg;
  logic rtc_hit;
  logic wake_now;
  logic in_down;

  assign in_down  = state_reg == spm_pkg::SPM_DOWN1 || state_reg == spm_pkg::SPM_DOWN2;
  assign pin_event = wake_pin_en_in && (wake_pin_rise_in ? (wake_pin_in && !pin_prev_reg)
                                                         : (!wake_pin_in && pin_prev_reg));
  assign rtc_hit  = rtc_wake_en_in && rtc_value_out >= rtc_compare_in;
  assign wake_now = pin_event || rtc_hit || (usb_enable_in && usb_wake_in);
  assign wake_req = wake_now || wake_pend_reg;

  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= wake_pin_in;
    end
  end

  // Stimulus seen while going down is latched and served once asleep
  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      wake_pend_reg <= 1'b0;
    end else if (in_down && wake_now) begin
      wake_pend_reg <= 1'b1;
    end else if (asleep_out) begin
      wake_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Real-time counter
  // ----------------------------------------------------------------
  // Not cleared by chip resets from the supervisor; only rst_in clears it
  logic lp_mode;
  assign lp_mode = lp_clk_sel_in && (state_reg == spm_pkg::SPM_ASLEEP
                                     || state_reg == spm_pkg::SPM_DOWN2
                                     || state_reg == spm_pkg::SPM_UP1);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rtc_value_out <= '0;
    end else if (lp_mode) begin
      if (lp_tick_in) begin
        rtc_value_out <= rtc_value_out + lp_increment_in;
      end
    end else begin
      rtc_value_out <= rtc_value_out + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Own prescaler and count, nothing shared with the real-time counter
  logic [$clog2(TICK_CYC)-1:0] pre_reg;
  logic                        ms_tick;
  logic                        wdt_run;

  assign wdt_run = wdt_enable_in && awake_out;
  assign ms_tick = wdt_run && pre_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1);

  always_ff @(posedge mclk_in) begin
    if (chip_rst || !wdt_run || ms_tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (chip_rst) begin
      wdt_count_out <= `SPM_WDT_RESET;
    end else if (wdt_refresh_in || !wdt_run) begin
      wdt_count_out <= wdt_timeout_in;
    end else if (ms_tick && wdt_count_out != '0) begin
      wdt_count_out <= wdt_count_out - 1'b1;
    end
  end
  assign wdt_expire = wdt_run && !wdt_refresh_in && ms_tick
                      && wdt_count_out == WDT_W'(1);

  // Survives the chip reset it caused; set wins over clear
  always_ff @(posedge mclk_in) begin
    if (rst_in || !all_good) begin
      wdt_reset_cause_out <= 1'b0;
    end else if (wdt_expire) begin
      wdt_reset_cause_out <= 1'b1;
    end else if (wdt_cause_clear_in) begin
      wdt_reset_cause_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Retained memory
  // ----------------------------------------------------------------
  spm_sleep_mem #(
    .DEPTH(MEM_DEPTH)
  ) u_mem (
    .mclk_in  (mclk_in),
    .wr_en_in (mem_wr_in),
    .addr_in  (mem_addr_in),
    .wdata_in (mem_wdata_in),
    .rdata_out(mem_rdata_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_brownout_reset:  assert property (!all_good |=> chip_reset_out)
    else $error("supply loss did not reset chip");
  a_por_release:     assert property (all_good && !wdt_expire && !seq_fail |=> !chip_reset_out)
    else $error("reset held with supplies good");
  a_wdt_stopped:     assert property (!awake_out |-> !ms_tick)
    else $error("watchdog ticked outside awake");
  a_wdt_expiry:      assert property (wdt_expire |=> chip_reset_out && wdt_reset_cause_out)
    else $error("watchdog expiry missed");
  a_wdt_reload:      assert property (wdt_refresh_in && !chip_rst |=> wdt_count_out == $past(wdt_timeout_in))
    else $error("refresh did not reload");
  a_sleep_start:     assert property (awake_out && sleep_req && !chip_rst |=> state_reg == spm_pkg::SPM_DOWN1)
    else $error("sleep request ignored");
  a_wake_only_sleep: assert property (in_down && wake_now && !chip_rst |=> wake_pend_reg)
    else $error("early wake not held");
  a_seq_fail:        assert property (seq_fail |=> chip_reset_out)
    else $error("transition supply loss no reset");
  a_rtc_awake:       assert property (awake_out ##1 !chip_reset_out |-> rtc_value_out == $past(rtc_value_out) + 1'b1)
    else $error("rtc not counting awake");
  a_node_off:        assert property (asleep_out && !chip_rst |-> !digital_power_en_out)
    else $error("digital node powered in sleep");

  c_sleep_cycle: cover property (asleep_out ##[1:40] awake_out);
  c_wdt_fire:    cover property (wdt_expire);
  c_held_wake:   cover property (wake_pend_reg && asleep_out);
endmodule
`default_nettype wire

// *** verif/spm_far_side.sv ***
/*
  Far side model: supply regulators and the low-power oscillator tick.
  Assumes the bench clock; the tick period is shortened for run time.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_far_side #(
  parameter int LP_CYC = 16
) (
  input  wire logic       mclk_in,
  input  wire logic [1:0] supply_on_in,
  output var  logic [1:0] supply_good_out,
  output var  logic       lp_tick_out
);
  int lp_cnt;
  initial begin
    lp_cnt = 0;
    supply_good_out = 2'b00;
    lp_tick_out = 1'b0;
  end
  // Power-good lags the switch by a cycle, as a real regulator would
  always @(posedge mclk_in) begin
    supply_good_out <= supply_on_in;
  end
  // Free running, so any window of LP_CYC edges holds exactly one tick
  always @(posedge mclk_in) begin
    lp_cnt <= (lp_cnt == LP_CYC - 1) ? 0 : lp_cnt + 1;
    lp_tick_out <= (lp_cnt == LP_CYC - 1);
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
/*
  Self-checking bench for the supervisor and power mode controller.
  Assumes a shortened watchdog tick and the far side model in spm_far_side.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TICK = 10;
  localparam int STEP = 4;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [1:0]  sup_on = 2'b00;
  logic [1:0]  sup_good;
  logic        wdt_en = 0, wdt_ref = 0, wdt_clr = 0, sw_req = 0, usb_req = 0;
  logic        usb_en = 0, usb_wake = 0, pin = 0, pin_en = 0, pin_rise = 1;
  logic        rtc_en = 0, lp_sel = 0, lp_tick, mem_wr = 0;
  logic [15:0] wdt_to = 16'h0003;
  logic [63:0] rtc_cmp = 64'hffff_ffff_ffff_ffff, lp_inc = 64'h0000_0000_0000_0005, rtc_ref;
  logic [6:0]  mem_addr = 7'h07;
  logic [7:0]  mem_wd = 8'ha5, mem_rd;
  logic        chip_rst, cause, pwr_en, awake, asleep;
  logic [15:0] wdt_cnt;
  logic [63:0] rtc;
  logic [2:0]  st;
  int          fail_count = 0, check_count = 0;

  spm_far_side #(.LP_CYC(16)) i_far (.mclk_in(mclk_in), .supply_on_in(sup_on),
    .supply_good_out(sup_good), .lp_tick_out(lp_tick));
  spm_top #(.TICK_CYC(TICK), .STEP_CYC(STEP)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .supply_good_in(sup_good), .wdt_enable_in(wdt_en), .wdt_timeout_in(wdt_to),
    .wdt_refresh_in(wdt_ref), .wdt_cause_clear_in(wdt_clr), .sw_sleep_req_in(sw_req),
    .usb_standby_req_in(usb_req), .usb_enable_in(usb_en), .usb_wake_in(usb_wake),
    .wake_pin_in(pin), .wake_pin_en_in(pin_en), .wake_pin_rise_in(pin_rise),
    .rtc_wake_en_in(rtc_en), .rtc_compare_in(rtc_cmp), .lp_clk_sel_in(lp_sel),
    .lp_increment_in(lp_inc), .lp_tick_in(lp_tick), .mem_wr_in(mem_wr),
    .mem_addr_in(mem_addr), .mem_wdata_in(mem_wd), .mem_rdata_out(mem_rd),
    .chip_reset_out(chip_rst), .wdt_reset_cause_out(cause), .wdt_count_out(wdt_cnt),
    .rtc_value_out(rtc), .digital_power_en_out(pwr_en), .awake_out(awake),
    .asleep_out(asleep), .power_state_out(st));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // ----------------------------------------
  // Helpers: drive after a rising edge, look at the falling edge
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_st(input logic [2:0] exp);
    check_count++;
    if (st !== exp) begin
      fail_count++;
      $display("mismatch power state expected %0h seen %0h", exp, st);
    end
  endtask
  task automatic wait_st(input logic [2:0] s, input int max, output int n);
    n = 0;
    while (st !== s && n < max) begin
      @(negedge mclk_in);
      n++;
    end
  endtask
  task automatic wait_rst(input logic v, input int max);
    int n;
    n = 0;
    while (chip_rst !== v && n < max) begin
      @(negedge mclk_in);
      n++;
    end
    chk("chip reset", v, chip_rst);
  endtask
  task automatic go_sleep(input bit by_usb, input bit poke);
    int n;
    cyc(1);
    if (by_usb) usb_req <= 1;
    else sw_req <= 1;
    cyc(1);
    usb_req <= 0;
    sw_req <= 0;
    if (poke) pin <= ~pin;
    @(negedge mclk_in);
    chk_st(spm_pkg::SPM_DOWN1);
    wait_st(spm_pkg::SPM_DOWN2, 20, n);
    chk("down1 cycles", STEP, n);
    chk("power in down2", 0, pwr_en);
    wait_st(spm_pkg::SPM_ASLEEP, 20, n);
    chk("down2 cycles", STEP, n);
    chk("asleep flag", 1, asleep);
  endtask
  task automatic wake_check(input string name);
    int n;
    wait_st(spm_pkg::SPM_UP1, 200, n);
    chk_st(spm_pkg::SPM_UP1);
    wait_st(spm_pkg::SPM_AWAKE, 20, n);
    chk("wake cycles", 2 * STEP, n);
    chk("power back", 1, pwr_en);
    chk("awake flag", 1, awake);
    $display("test %s done", name);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_supervisor();
    cyc(1);
    rst_in <= 0;
    sup_on <= 2'b01;
    cyc(10);
    wait_rst(1, 2);
    sup_on <= 2'b11;
    wait_rst(0, 10);
    cyc(1);
    sup_on <= 2'b10;
    wait_rst(1, 5);
    cyc(1);
    sup_on <= 2'b11;
    wait_rst(0, 10);
    chk("cause after brown-out", 0, cause);
    cyc(1);
    sw_req <= 1;
    cyc(1);
    sw_req <= 0;
    sup_on <= 2'b01;
    wait_rst(1, 5);
    cyc(1);
    sup_on <= 2'b11;
    wait_rst(0, 10);
    chk_st(spm_pkg::SPM_AWAKE);
    $display("test supervisor done");
  endtask
  task automatic t_watchdog();
    int n;
    rtc_ref = rtc;
    cyc(1);
    wdt_en <= 1;
    for (int i = 0; i < 5; i++) begin
      wdt_ref <= 1;
      cyc(1);
      wdt_ref <= 0;
      @(negedge mclk_in);
      chk("reload", 3, wdt_cnt);
      chk("no early reset", 0, chip_rst);
      cyc(2 * TICK);
    end
    n = 0;
    while (chip_rst !== 1'b1 && n < 100) begin
      @(negedge mclk_in);
      n++;
    end
    chk("expiry window", 1, n > 1 && n <= TICK + 1);
    chk("cause set", 1, cause);
    cyc(1);
    wdt_en <= 0;
    wait_rst(0, 20);
    chk("cause kept", 1, cause);
    chk("rtc not shared", 1, rtc > rtc_ref);
    cyc(1);
    wdt_clr <= 1;
    cyc(1);
    wdt_clr <= 0;
    cyc(2);
    chk("cause cleared", 0, cause);
    $display("test watchdog done");
  endtask
  task automatic t_sleep_pin();
    cyc(1);
    mem_wr <= 1;
    wdt_en <= 1;
    wdt_ref <= 1;
    cyc(1);
    mem_wr <= 0;
    wdt_ref <= 0;
    go_sleep(0, 0);
    cyc(60);
    chk("no reset asleep", 0, chip_rst);
    chk("wdt held", 3, wdt_cnt);
    wdt_en <= 0;
    pin_en <= 1;
    pin <= 1;
    wake_check("pin rise");
    cyc(1);
    mem_wd <= 8'h00;
    cyc(2);
    chk("retained byte", 8'ha5, mem_rd);
  endtask
  task automatic t_sleep_held();
    cyc(1);
    pin_rise <= 0;
    go_sleep(1, 1);
    wake_check("held fall");
  endtask
  task automatic t_usb_wake();
    cyc(1);
    pin_en <= 0;
    go_sleep(0, 0);
    cyc(1);
    usb_wake <= 1;
    cyc(10);
    @(negedge mclk_in);
    chk_st(spm_pkg::SPM_ASLEEP);
    cyc(1);
    usb_en <= 1;
    wake_check("usb wake");
    cyc(1);
    usb_wake <= 0;
  endtask
  task automatic t_rtc();
    @(negedge mclk_in);
    rtc_ref = rtc;
    cyc(10);
    @(negedge mclk_in);
    chk("rtc awake", rtc_ref + 10, rtc);
    cyc(1);
    lp_sel <= 1;
    go_sleep(0, 0);
    rtc_ref = rtc;
    repeat (32) @(negedge mclk_in);
    chk("rtc asleep", rtc_ref + 10, rtc);
    cyc(1);
    rtc_cmp <= rtc + 20;
    rtc_en <= 1;
    wake_check("rtc compare");
    chk("rtc reached", 1, rtc >= rtc_cmp);
    cyc(1);
    rtc_en <= 0;
    lp_sel <= 0;
  endtask

  initial begin
    #200us;
    fail_count++;
    test_done();
  end
  initial begin
    cyc(20);
    t_supervisor();
    t_watchdog();
    t_sleep_pin();
    t_sleep_held();
    t_usb_wake();
    t_rtc();
    test_done();
  end
endmodule
`default_nettype wire
